// ===== rtl/pss_bus_state.sv
// Talk, listen, remote and lockout tracking from bus command bytes.
// Assumes cmdStb marks one command byte received with attention true.
`timescale 1ns/1ps
`default_nettype none
module pss_bus_state
  import pss_pkg::*;
(
  input  wire logic       sys_clk,     // System clock
  input  wire logic       srst,        // Sync reset, high
  input  wire logic [4:0] primAddr,    // Effective primary address
  input  wire logic       cmdStb,      // Command byte strobe
  input  wire logic [7:0] cmdByte,     // Command byte
  input  wire logic       remEnable,   // Remote enable line true
  input  wire logic       localKey,    // Local key press pulse
  output logic            talkLamp,    // Addressed to talk
  output logic            listenLamp,  // Addressed to listen
  output logic            remoteLamp,  // Bus controlled
  output logic            lockout      // Local lockout in force
);

  typedef struct packed {
    logic talk;
    logic listen;
    logic remote;
    logic llo;
  } pss_bus_s;

  pss_bus_s st_ff;
  pss_bus_s nxt_st;

  // Address compare shared by talk and listen decode
  function automatic logic addr_hit(input logic [7:0] b, input logic [7:0] base,
                                    input logic [4:0] a);
    addr_hit = (b == (base | {3'b000, a}));
  endfunction

  // Decode addressing, remote entry and return to local
  always_comb
  begin
    nxt_st = st_ff;
    if (cmdStb)
    begin
      if (addr_hit(cmdByte, CMD_TALK_BASE, primAddr))
        nxt_st.talk = 1'b1;
      else if (cmdByte[7:5] == CMD_TALK_BASE[7:5] || cmdByte == CMD_UNTALK)
        nxt_st.talk = 1'b0;
      if (addr_hit(cmdByte, CMD_LISTEN_BASE, primAddr))
      begin
        nxt_st.listen = 1'b1;
        nxt_st.remote = remEnable;
      end
      else if (cmdByte == CMD_UNLISTEN)
        nxt_st.listen = 1'b0;
      if (cmdByte == CMD_LOCKOUT)
        nxt_st.llo = 1'b1;
      if (cmdByte == CMD_GO_LOCAL && st_ff.listen)
        nxt_st.remote = 1'b0;
    end
    if (localKey && !st_ff.llo)
      nxt_st.remote = 1'b0;
    if (!remEnable)
    begin
      nxt_st.remote = 1'b0;
      nxt_st.llo = 1'b0;
    end
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign talkLamp   = st_ff.talk;
  assign listenLamp = st_ff.listen;
  assign remoteLamp = st_ff.remote;
  assign lockout    = st_ff.llo;

endmodule
`default_nettype wire

// ===== rtl/pss_err_latch.sv
// Latched error causes, one sticky flag per cause, reported on query.
// Assumes event inputs are one-cycle pulses synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module pss_err_latch
  import pss_pkg::*;
(
  input  wire logic              sys_clk,      // System clock
  input  wire logic              srst,         // Sync reset, high
  input  wire logic [ERR_W-1:0]  errEvent,     // Cause pulses
  input  wire logic              queryStb,     // Error query command
  output logic      [ERR_W-1:0]  errFlags,     // Pending causes
  output logic      [ERR_W-1:0]  errReport,    // Snapshot for host
  output logic                   errReportVld  // Snapshot valid pulse
);

  typedef struct packed {
    logic [ERR_W-1:0] flags;
    logic [ERR_W-1:0] report;
    logic             vld;
  } pss_errl_s;

  pss_errl_s st_ff;
  pss_errl_s nxt_st;

  // Query takes a snapshot and clears; a cause in the same cycle stays set
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.vld = 1'b0;
    if (queryStb)
    begin
      nxt_st.report = st_ff.flags | errEvent;
      nxt_st.vld = 1'b1;
      nxt_st.flags = errEvent;
    end
    else
    begin
      nxt_st.flags = st_ff.flags | errEvent;
    end
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign errFlags     = st_ff.flags;
  assign errReport    = st_ff.report;
  assign errReportVld = st_ff.vld;

endmodule
`default_nettype wire

// ===== rtl/pss_pkg.sv
// Package for the power-up self-test and error-status block.
// Assumes a single 250 MHz system clock shared by all users.
package pss_pkg;

  // Clock and power-up duration
  localparam int unsigned CLK_MHZ       = 250;
  localparam int unsigned PWRUP_TIME_MS = 5000;
  localparam int unsigned PWRUP_CYC     = PWRUP_TIME_MS * 1000 * CLK_MHZ;
  localparam int unsigned TMR_W         = 31;

  // Indicator lamp positions in the diagnostic lamp vector
  localparam int unsigned LAMP_D3 = 0;
  localparam int unsigned LAMP_D6 = 1;
  localparam int unsigned LAMP_D7 = 2;
  localparam int unsigned LAMP_D8 = 3;
  localparam int unsigned LAMP_D9 = 4;
  localparam int unsigned LAMP_W  = 5;

  // Latched error cause positions
  localparam int unsigned ERR_PROG    = 0;
  localparam int unsigned ERR_WORK    = 1;
  localparam int unsigned ERR_CARD    = 2;
  localparam int unsigned ERR_SETUP   = 3;
  localparam int unsigned ERR_LOOP    = 4;
  localparam int unsigned ERR_CHAIN   = 5;
  localparam int unsigned ERR_BADCMD  = 6;
  localparam int unsigned ERR_BADOPT  = 7;
  localparam int unsigned ERR_INVALID = 8;
  localparam int unsigned ERR_NOTREM  = 9;
  localparam int unsigned ERR_TRIGCOL = 10;
  localparam int unsigned ERR_W       = 11;

  // Address switch, step and setup figures
  localparam logic [5:0] MASTER_ADDR_OFS = 6'h1E;
  localparam logic [6:0] RELAY_STEP_INIT = 7'h00;
  localparam logic [6:0] MEM_STEP_INIT   = 7'h01;
  localparam logic [6:0] SETUP_FIRST     = 7'h01;
  localparam logic [6:0] SETUP_COUNT     = 7'h64;

  // Bus command bytes seen with attention asserted
  localparam logic [7:0] CMD_LISTEN_BASE = 8'h20;
  localparam logic [7:0] CMD_TALK_BASE   = 8'h40;
  localparam logic [7:0] CMD_UNLISTEN    = 8'h3F;
  localparam logic [7:0] CMD_UNTALK      = 8'h5F;
  localparam logic [7:0] CMD_LOCKOUT     = 8'h11;
  localparam logic [7:0] CMD_GO_LOCAL    = 8'h01;

  // Check engine selections
  typedef enum logic [2:0] {
    CHK_PROG, CHK_WORK, CHK_CARD, CHK_SETUP, CHK_LOOP
  } pss_chk_e;

endpackage

// ===== rtl/pss_selftest_top.sv
// Power-up self-test sequencer, initial state and error status.
// Assumes external check engines answer chkReq with a chkDone pulse,
// and that bus, key and error inputs are synchronous one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module pss_selftest_top
  import pss_pkg::*;
#(
  parameter int unsigned PWRUP_CYCLES = PWRUP_CYC // Power-up length, cycles
)
(
  input  wire logic              sys_clk,         // 250 MHz clock
  input  wire logic              srst,            // Sync reset, power-on
  input  wire logic              allPowered,      // Every chained unit up
  input  wire logic [5:0]        addrSwitch,      // Rear address switch
  input  wire logic              savedRoleMaster, // Saved role was master
  input  wire logic              cardPresent,     // Card fitted in slot
  input  wire logic              configChanged,   // Card set differs
  input  wire logic              chkDone,         // Check engine finished
  input  wire logic              chkPass,         // Check result good
  input  wire logic              refmtAck,        // Setup reformat done
  input  wire logic              keyPress,        // Any front panel key
  input  wire logic              localKey,        // Local key press
  input  wire logic              busOp,           // Any bus operation
  input  wire logic              cmdStb,          // Bus command byte strobe
  input  wire logic [7:0]        cmdByte,         // Bus command byte
  input  wire logic              remEnable,       // Remote enable line
  input  wire logic              execChar,        // Execute char received
  input  wire logic              trigIn,          // Trigger arrived
  input  wire logic              matrixReady,     // Ready indication
  input  wire logic [4:0]        linkFault,       // Ovr,par,frm,cnt,tmo
  input  wire logic              badCmd,          // Unknown command
  input  wire logic              badOpt,          // Unknown option
  input  wire logic              badParam,        // Out-of-range input
  input  wire logic              errQuery,        // Error query command
  input  wire logic              trigEnSet,       // Enable triggers
  input  wire logic              trigEnClr,       // Disable triggers
  output logic                   chkReq,          // Check request level
  output pss_chk_e               chkSel,          // Which check
  output logic                   setupClrStb,     // Clear failing setups
  output logic                   refmtStb,        // Reformat one setup
  output logic      [6:0]        refmtIdx,        // Setup being reformatted
  output logic                   displayBlank,    // Display blanked
  output logic                   errLamp,         // Error indicator
  output logic      [LAMP_W-1:0] diagLamps,       // D3,D6,D7,D8,D9 lamps
  output logic                   allLampsOn,      // Display test
  output logic                   roleMaster,      // Running as master
  output logic                   masterSel,       // Switch marks master
  output logic      [4:0]        busAddr,         // Effective bus address
  output logic                   relayOpenAll,    // Open every relay pulse
  output logic                   showLive,        // Show live relay setup
  output logic      [6:0]        relayStep,       // Relay step field
  output logic      [6:0]        memStep,         // Memory step field
  output logic                   trigEnable,      // Triggers enabled
  output logic                   testDone,        // Power-up complete
  output logic                   panelEnable,     // Panel keys honoured
  output logic                   talkLamp,        // Talk lamp
  output logic                   listenLamp,      // Input-addressed lamp
  output logic                   remoteLamp,      // Bus-controlled lamp
  output logic      [ERR_W-1:0]  errFlags,        // Pending causes
  output logic      [ERR_W-1:0]  errReport,       // Query answer
  output logic                   errReportVld     // Query answer valid
);

  typedef enum logic [3:0] {
    ST_WAIT_PWR, ST_PROG, ST_WORK, ST_CARD, ST_SETUP, ST_CONFIG,
    ST_REFMT, ST_LOOP, ST_LOOP_ERR, ST_LAMP, ST_INIT, ST_RUN
  } pss_state_e;

  typedef struct packed {
    pss_state_e       state;
    logic             req;
    pss_chk_e         sel;
    logic             setupClr;
    logic             refStb;
    logic [6:0]       refIdx;
    logic             refWait;
    logic             blank;
    logic             errLamp;
    logic [LAMP_W-1:0] lamps;
    logic             allOn;
    logic             master;
    logic             masterSw;
    logic [4:0]       addr;
    logic             openAll;
    logic             live;
    logic [6:0]       rStep;
    logic [6:0]       mStep;
    logic             trigEn;
    logic             done;
    logic             panel;
    logic [TMR_W-1:0] tmr;
  } pss_top_s;

  localparam logic [TMR_W-1:0] PWRUP_LAST = TMR_W'(PWRUP_CYCLES - 1);

  pss_top_s         st_ff;
  pss_top_s         nxt_st;
  logic [ERR_W-1:0] errEvent;
  logic             lockoutLvl;

  // Decode of the rear switch into role mark and effective address
  function automatic logic [5:0] eff_addr(input logic [5:0] sw);
    eff_addr = (sw >= MASTER_ADDR_OFS) ? sw - MASTER_ADDR_OFS : sw;
  endfunction

  // Cause pulses gathered for the sticky flags; self-test causes added below
  always_comb
  begin
    errEvent = '0;
    errEvent[ERR_CHAIN]   = |linkFault;
    errEvent[ERR_BADCMD]  = badCmd;
    errEvent[ERR_BADOPT]  = badOpt;
    errEvent[ERR_INVALID] = badParam;
    errEvent[ERR_NOTREM]  = execChar && !remoteLamp;
    errEvent[ERR_TRIGCOL] = trigIn && !matrixReady;
    if (st_ff.req && chkDone && !chkPass)
    begin
      case (st_ff.sel)
        CHK_PROG:  errEvent[ERR_PROG]  = 1'b1;
        CHK_WORK:  errEvent[ERR_WORK]  = 1'b1;
        CHK_CARD:  errEvent[ERR_CARD]  = 1'b1;
        CHK_SETUP: errEvent[ERR_SETUP] = 1'b1;
        CHK_LOOP:  errEvent[ERR_LOOP]  = 1'b1;
        default:   errEvent[ERR_PROG]  = 1'b0;
      endcase
    end
  end

  // Sequencer: tests run in fixed order, failures latch lamps and go on; a loop failure waits for a key or bus operation
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.setupClr = 1'b0;
    nxt_st.refStb   = 1'b0;
    nxt_st.openAll  = 1'b0;
    nxt_st.panel    = st_ff.done && !remoteLamp;
    if (st_ff.state != ST_WAIT_PWR && st_ff.tmr != PWRUP_LAST)
      nxt_st.tmr = st_ff.tmr + TMR_W'(1);
    // Lamps drop on the next operation, but a new fault in the same cycle wins
    if (keyPress || busOp)
    begin
      nxt_st.lamps[LAMP_D6] = 1'b0;
      nxt_st.lamps[LAMP_D7] = 1'b0;
      nxt_st.lamps[LAMP_D8] = 1'b0;
      nxt_st.lamps[LAMP_D9] = 1'b0;
      nxt_st.lamps[LAMP_D3] = 1'b0;
      nxt_st.errLamp = 1'b0;
    end
    if (errEvent[ERR_PROG])
      nxt_st.lamps[LAMP_D6] = 1'b1;
    if (errEvent[ERR_WORK])
      nxt_st.lamps[LAMP_D7] = 1'b1;
    if (errEvent[ERR_CARD])
      nxt_st.lamps[LAMP_D8] = 1'b1;
    if (errEvent[ERR_SETUP])
      nxt_st.lamps[LAMP_D9] = 1'b1;
    if (errEvent[ERR_LOOP])
      nxt_st.lamps[LAMP_D3] = 1'b1;
    if (|errEvent)
      nxt_st.errLamp = 1'b1;
    if (st_ff.done)
    begin
      if (trigEnSet)
        nxt_st.trigEn = 1'b1;
      if (trigEnClr)
        nxt_st.trigEn = 1'b0;
    end
    case (st_ff.state)
      ST_WAIT_PWR:
      begin
        nxt_st.masterSw = addrSwitch >= MASTER_ADDR_OFS;
        nxt_st.addr = 5'(eff_addr(addrSwitch));
        if (allPowered)
        begin
          nxt_st.state = ST_PROG;
          nxt_st.req = 1'b1;
          nxt_st.sel = CHK_PROG;
        end
      end
      ST_PROG, ST_WORK, ST_CARD, ST_SETUP:
      begin
        if (chkDone)
        begin
          nxt_st.req = 1'b0;
          if (st_ff.state == ST_SETUP && !chkPass)
            nxt_st.setupClr = 1'b1;
          case (st_ff.state)
            ST_PROG:
            begin
              nxt_st.state = ST_WORK;
              nxt_st.req = 1'b1;
              nxt_st.sel = CHK_WORK;
            end
            ST_WORK:
            begin
              nxt_st.state = ST_CARD;
              nxt_st.req = cardPresent;
              nxt_st.sel = CHK_CARD;
            end
            ST_CARD:
            begin
              nxt_st.state = ST_SETUP;
              nxt_st.req = 1'b1;
              nxt_st.sel = CHK_SETUP;
            end
            default:
              nxt_st.state = ST_CONFIG;
          endcase
        end
        else if (st_ff.state == ST_CARD && !st_ff.req)
        begin
          nxt_st.state = ST_SETUP;
          nxt_st.req = 1'b1;
          nxt_st.sel = CHK_SETUP;
        end
      end
      ST_CONFIG:
      begin
        if (configChanged)
        begin
          nxt_st.state = ST_REFMT;
          nxt_st.blank = 1'b1;
          nxt_st.refIdx = SETUP_FIRST;
          nxt_st.refStb = 1'b1;
          nxt_st.refWait = 1'b1;
        end
        else
          nxt_st.state = ST_LOOP;
      end
      ST_REFMT:
      begin
        if (refmtAck)
        begin
          if (st_ff.refIdx == SETUP_COUNT)
          begin
            nxt_st.blank = 1'b0;
            nxt_st.refWait = 1'b0;
            nxt_st.state = ST_LOOP;
          end
          else
          begin
            nxt_st.refIdx = st_ff.refIdx + 7'h01;
            nxt_st.refStb = 1'b1;
          end
        end
      end
      ST_LOOP:
      begin
        if (!savedRoleMaster)
        begin
          nxt_st.master = 1'b0;
          nxt_st.state = ST_LAMP;
        end
        else if (!st_ff.req)
        begin
          nxt_st.req = 1'b1;
          nxt_st.sel = CHK_LOOP;
        end
        else if (chkDone)
        begin
          nxt_st.req = 1'b0;
          nxt_st.master = chkPass;
          nxt_st.state = chkPass ? ST_LAMP : ST_LOOP_ERR;
        end
      end
      ST_LOOP_ERR:
      begin
        if (keyPress || busOp)
        begin
          nxt_st.master = 1'b0;
          nxt_st.state = ST_LAMP;
        end
      end
      ST_LAMP:
      begin
        nxt_st.allOn = 1'b1;
        if (st_ff.allOn && st_ff.tmr == PWRUP_LAST)
        begin
          nxt_st.allOn = 1'b0;
          nxt_st.state = ST_INIT;
        end
      end
      ST_INIT:
      begin
        nxt_st.openAll = 1'b1;
        nxt_st.live = 1'b1;
        nxt_st.rStep = RELAY_STEP_INIT;
        nxt_st.mStep = MEM_STEP_INIT;
        nxt_st.trigEn = 1'b0;
        nxt_st.done = 1'b1;
        nxt_st.state = ST_RUN;
      end
      ST_RUN:
        nxt_st.state = ST_RUN;
      default:
        nxt_st.state = ST_WAIT_PWR;
    endcase
  end

  // State register; reset values double as the power-on state
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      st_ff <= '0;
      st_ff.state <= ST_WAIT_PWR;
      st_ff.sel <= CHK_PROG;
      st_ff.rStep <= RELAY_STEP_INIT;
      st_ff.mStep <= MEM_STEP_INIT;
    end
    else
      st_ff <= nxt_st;
  end

  // Sticky causes for the error query
  pss_err_latch u_err_latch
  (
    .sys_clk      (sys_clk),
    .srst         (srst),
    .errEvent     (errEvent),
    .queryStb     (errQuery),
    .errFlags     (errFlags),
    .errReport    (errReport),
    .errReportVld (errReportVld)
  );

  // Bus addressing and remote state
  pss_bus_state u_bus_state
  (
    .sys_clk    (sys_clk),
    .srst       (srst),
    .primAddr   (st_ff.addr),
    .cmdStb     (cmdStb),
    .cmdByte    (cmdByte),
    .remEnable  (remEnable),
    .localKey   (localKey),
    .talkLamp   (talkLamp),
    .listenLamp (listenLamp),
    .remoteLamp (remoteLamp),
    .lockout    (lockoutLvl)
  );

  assign chkReq       = st_ff.req;
  assign chkSel       = st_ff.sel;
  assign setupClrStb  = st_ff.setupClr;
  assign refmtStb     = st_ff.refStb;
  assign refmtIdx     = st_ff.refIdx;
  assign displayBlank = st_ff.blank;
  assign errLamp      = st_ff.errLamp;
  assign diagLamps    = st_ff.lamps;
  assign allLampsOn   = st_ff.allOn;
  assign roleMaster   = st_ff.master;
  assign masterSel    = st_ff.masterSw;
  assign busAddr      = st_ff.addr;
  assign relayOpenAll = st_ff.openAll;
  assign showLive     = st_ff.live;
  assign relayStep    = st_ff.rStep;
  assign memStep      = st_ff.mStep;
  assign trigEnable   = st_ff.trigEn;
  assign testDone     = st_ff.done;
  assign panelEnable  = st_ff.panel;

endmodule
`default_nettype wire

// ===== tb/pss_chk_model.sv
// Check engine and reformat responder beyond the self-test block.
// Assumes the bench sets answer delay and which checks fail.
`timescale 1ns/1ps
`default_nettype none
module pss_chk_model
  import pss_pkg::*;
(
  input  wire logic       sys_clk,  // Clock
  input  wire logic       srst,     // Reset
  input  wire logic       chkReq,   // Request
  input  wire pss_chk_e   chkSel,   // Which check
  input  wire logic       refmtStb, // Reformat
  input  wire logic [4:0] failMask, // Failing checks
  input  wire logic [2:0] lat,      // Answer delay
  output logic            chkDone,  // Finished
  output logic            chkPass,  // Result
  output logic            refmtAck  // Setup done
);
  logic [2:0] cnt;
  logic       noise;
  // Answer after lat cycles, then rest a cycle for the handoff
  always_ff @(posedge sys_clk)
  begin
    chkDone  <= 1'b0;
    refmtAck <= refmtStb & ~srst;
    noise    <= srst ? 1'b0 : ~noise;
    if (srst || !chkReq || chkDone)
      cnt <= '0;
    else if (cnt == lat)
      chkDone <= 1'b1;
    else
      cnt <= cnt + 3'h1;
  end
  // Result wanders when not beside done, so stale reads show
  assign chkPass = chkDone ? ~failMask[chkSel] : noise;
endmodule
`default_nettype wire

// ===== tb/pss_selftest_assertions.sv
// Checker for the power-up self-test block.
// Assumes it is bound to pss_selftest_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module pss_selftest_assertions
  import pss_pkg::*;
(
  input wire logic             sys_clk,      // Clock
  input wire logic             srst,         // Reset
  input wire logic             refmtStb,     // Reformat
  input wire logic [6:0]       refmtIdx,     // Setup
  input wire logic             displayBlank, // Blank
  input wire logic             testDone,     // Done
  input wire logic             relayOpenAll, // Open
  input wire logic             showLive,     // Live
  input wire logic             trigEnable,   // Triggers
  input wire logic             allLampsOn,   // Lamp test
  input wire logic             badCmd,       // Bad command
  input wire logic             errQuery,     // Query
  input wire logic [ERR_W-1:0] errFlags,     // Causes
  input wire logic [ERR_W-1:0] errReport,    // Answer
  input wire logic             errReportVld, // Valid
  input wire logic             execChar,     // Execute
  input wire logic             remoteLamp,   // Remote
  input wire logic             trigIn,       // Trigger
  input wire logic             matrixReady,  // Ready
  input wire logic             setupClrStb,  // Setup clear
  input wire logic [LAMP_W-1:0] diagLamps,   // Lamps
  input wire logic             panelEnable   // Panel
);
  // One domain; a reset voids every pending check
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  a_refmt_blank: assert property (refmtStb |-> displayBlank && refmtIdx inside {[1:100]})
    else $error("reformat outside blanking");
  a_init_state: assert property ($rose(testDone) |-> relayOpenAll && showLive && !trigEnable)
    else $error("bad state after tests");
  a_lamps_first: assert property ($rose(testDone) |-> $past(allLampsOn, 2))
    else $error("lamp test skipped");
  a_cause_latch: assert property (badCmd |=> errFlags[ERR_BADCMD])
    else $error("bad command not latched");
  a_query_answer: assert property (errQuery |=> errReportVld &&
    errReport[ERR_BADCMD] == $past(errFlags[ERR_BADCMD] | badCmd)) else $error("bad report");
  a_not_remote: assert property (execChar && !remoteLamp |=> errFlags[ERR_NOTREM])
    else $error("not-in-remote missed");
  a_trig_collide: assert property (trigIn && !matrixReady |=> errFlags[ERR_TRIGCOL])
    else $error("collision missed");
  a_panel_locked: assert property (remoteLamp |=> !panelEnable)
    else $error("panel live in remote");
  a_setup_clear: assert property ($rose(diagLamps[LAMP_D9]) |-> setupClrStb)
    else $error("failing setups not cleared");
  a_refmt_count: assert property ($fell(displayBlank) |-> refmtIdx == SETUP_COUNT)
    else $error("reformat ended early");
  c_done: cover property ($rose(testDone));
  c_query: cover property (errQuery ##1 errReportVld);
  c_remote: cover property ($rose(remoteLamp));
endmodule
bind pss_selftest_top pss_selftest_assertions pss_selftest_assertions_inst (.*);
`default_nettype wire

// ===== tb/pss_selftest_top_test.sv
// Bench for the power-up self-test and error-status block.
// Assumes pss_chk_model answers the check and reformat requests.
`timescale 1ns/1ps
`default_nettype none
module pss_selftest_top_test
  import pss_pkg::*;
;
  logic sys_clk, srst, allPowered, savedRoleMaster, cardPresent, configChanged, chkReq;
  logic chkDone, chkPass, refmtAck, remEnable, matrixReady, keyPress, localKey, busOp;
  logic cmdStb, execChar, trigIn, badCmd, badOpt, badParam, errQuery, trigEnSet, trigEnClr;
  logic setupClrStb, refmtStb, displayBlank, errLamp, allLampsOn, roleMaster, masterSel;
  logic relayOpenAll, showLive, trigEnable, testDone, panelEnable, talkLamp, listenLamp;
  logic remoteLamp, errReportVld, look, prevDone;
  logic [5:0]       addrSwitch;
  logic [7:0]       cmdByte;
  logic [4:0]       linkFault, busAddr, diagLamps, failMask, n;
  logic [6:0]       refmtIdx, relayStep, memStep;
  logic [ERR_W-1:0] errFlags, errReport;
  logic [2:0]       lat;
  logic [11:0]      ev;
  pss_chk_e         chkSel;
  logic [15:0]      qq[$];
  int               nMismatch, comparisons, seed, i;
  assign {trigEnClr, trigEnSet, errQuery, badParam, badOpt, badCmd, trigIn, execChar,
    cmdStb, busOp, localKey, keyPress} = ev;
  pss_selftest_top #(.PWRUP_CYCLES(600)) pss_selftest_top_inst (.*);
  pss_chk_model pss_chk_model_inst (.*);
  // Free-running 250 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic cmp(input string what, input logic [15:0] got);
    logic [15:0] exp;
    exp = qq.pop_front();
    comparisons++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic pulse(input logic [11:0] m, input logic [7:0] b);
    @(negedge sys_clk);
    ev <= m;
    cmdByte <= b;
    @(negedge sys_clk);
    ev <= '0;
  endtask
  task automatic probe(input logic [15:0] e);
    qq.push_back(e);
    @(negedge sys_clk);
    look <= 1'b1;
    @(negedge sys_clk);
    look <= 1'b0;
  endtask
  task automatic power_up(input logic mst, input logic [5:0] sw, input logic [4:0] f);
    srst = 1'b1;
    allPowered = 1'b0;
    savedRoleMaster = mst;
    addrSwitch = sw;
    failMask = f;
    lat = 3'($random(seed));
    repeat (3) @(negedge sys_clk);
    srst = 1'b0;
    @(negedge sys_clk);
    allPowered = 1'b1;
  endtask
  task automatic final_report;
    if (qq.size() != 0)
    begin
      nMismatch++;
      $display("MISMATCH pending expected 0 seen %0d", qq.size());
    end
    $display("Comparisons %0d mismatches %0d", comparisons, nMismatch);
    if (nMismatch == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Results read at the falling edge, clear of design updates
  always @(negedge sys_clk)
  begin
    if (errReportVld === 1'b1)
      cmp("errReport", 16'(errReport));
    if (look === 1'b1)
      cmp("lamps", {5'h0, trigEnable, errLamp, diagLamps, talkLamp, listenLamp,
        remoteLamp, panelEnable});
    if (testDone === 1'b1 && !prevDone)
      cmp("powerUp", {roleMaster, masterSel, busAddr, diagLamps, trigEnable, showLive,
        memStep[0], relayStep[0]});
    prevDone = (testDone === 1'b1);
  end
  // Cut a hang short well past the expected run length
  initial
  begin
    repeat (6000) @(posedge sys_clk);
    nMismatch++;
    final_report();
  end
  // Main sequence
  initial
  begin
    seed = 32'h0000_baaa;
    {nMismatch, comparisons} = '0;
    {srst, allPowered, savedRoleMaster, remEnable, matrixReady, look, prevDone} = 7'h40;
    {addrSwitch, cmdByte, linkFault, ev, failMask, lat} = '0;
    {cardPresent, configChanged} = 2'h3;
    n = 5'($random(seed)) & 5'h0F;
    power_up(1'b1, MASTER_ADDR_OFS + 6'(n), 5'h1D);
    for (i = 0; i < 2000 && diagLamps[LAMP_D3] !== 1'b1; i++)
      @(negedge sys_clk);
    probe(16'h03B0);
    qq.push_back({2'b01, n, 9'h006});
    pulse(12'h001, 8'h00);
    for (i = 0; i < 2000 && testDone !== 1'b1; i++)
      @(negedge sys_clk);
    qq.push_back(16'h001D);
    pulse(12'h200, 8'h00);
    $display("power-up with failures done");
    {cardPresent, configChanged} = 2'h0;
    n = 5'($unsigned($random(seed)) % 30);
    qq.push_back({2'b00, n, 9'h006});
    power_up(1'b0, {1'b0, n}, 5'h00);
    for (i = 0; i < 2000 && testDone !== 1'b1; i++)
      @(negedge sys_clk);
    $display("clean power-up done");
    pulse(12'h010, 8'h00);
    pulse(12'h020, 8'h00);
    pulse(12'h1C0, 8'h00);
    linkFault <= 5'h01 << ($unsigned($random(seed)) % 5);
    pulse(12'h000, 8'h00);
    linkFault <= '0;
    qq.push_back(16'h07E0);
    pulse(12'h200, 8'h00);
    qq.push_back(16'h0000);
    pulse(12'h200, 8'h00);
    pulse(12'h004, 8'h00);
    remEnable = 1'b1;
    pulse(12'h008, {3'b001, n});
    probe(16'h0006);
    pulse(12'h010, 8'h00);
    qq.push_back(16'h0000);
    pulse(12'h200, 8'h00);
    pulse(12'h008, {3'b010, n});
    pulse(12'h008, CMD_UNLISTEN);
    probe(16'h000A);
    pulse(12'h008, CMD_LOCKOUT);
    pulse(12'h002, 8'h00);
    probe(16'h000A);
    remEnable = 1'b0;
    probe(16'h0009);
    remEnable = 1'b1;
    pulse(12'h008, {3'b001, n});
    pulse(12'h002, 8'h00);
    probe(16'h000D);
    pulse(12'h400, 8'h00);
    probe(16'h040D);
    pulse(12'hC00, 8'h00);
    probe(16'h000D);
    matrixReady = 1'($random(seed));
    pulse(12'h020, 8'h00);
    qq.push_back({5'h00, ~matrixReady, 10'h000});
    pulse(12'h200, 8'h00);
    repeat (2) @(negedge sys_clk);
    $display("bus and error tests done");
    final_report();
  end
endmodule
`default_nettype wire
